// *** design/tgc_pkg.sv ***
package tgc_pkg;
    localparam logic [3:0] TGC_ADDR_CTRL = 4'h0;   // gate control register
    localparam logic [3:0] TGC_ADDR_TMR = 4'h4;    // timer on register
    localparam int TGC_BIT_GE = 7;
    localparam int TGC_BIT_POL = 6;
    localparam int TGC_BIT_TM = 5;
    localparam int TGC_BIT_SPM = 4;
    localparam int TGC_BIT_GO = 3;
    localparam int TGC_BIT_VAL = 2;
    localparam int TGC_BIT_TON = 0;
    localparam int TGC_BIT_FULL = 1;
    localparam logic [7:0] TGC_CTRL_RST = 8'h00;
    localparam logic [1:0] TGC_RESP_OKAY = 2'b00;
    localparam logic [1:0] TGC_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic ge;
        logic pol;
        logic tm;
        logic spm;
        logic go;
        logic [1:0] gss;
        logic ton;
    } tgc_ctrl_t;

    typedef enum logic [2:0] {
        TGC_SP_IDLE = 3'b001,
        TGC_SP_ARMED = 3'b010,
        TGC_SP_OPEN = 3'b100
    } tgc_sp_t;
endpackage : tgc_pkg

// *** design/tgc_gate.sv ***
// Behaviour
// R1: timer on with gate enable set counts only while the gate is active; timer off ignores it.
// R2: with the timer on and gate enable clear, the counter advances on every counting clock.
// R3: gate polarity one means count while the gate is high, zero means count while it is low.
// R4: toggle mode bit enables toggle mode; clearing it clears the toggle flip-flop.
// R5: in toggle mode the toggle flip-flop inverts on each gate rising edge and becomes the gate; the code holds it while single-pulse mode is idle.
// R6: single-pulse mode bit puts the gate under single-pulse control; clearing it disables it.
// R7: single-pulse status is one while armed, zero once done or idle, and hardware clears it.
// R8: gate value is read-only and shows the conditioned gate regardless of gate enable.
// R9: a two-bit source field selects the gate signal among pin, timer overflow and period match.
// R10: power-on or brown-out reset clears control bits and status; other resets keep them.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module tgc_gate
    import tgc_pkg::*;
(
    input wire logic clk,              // timer clock
    input wire logic rstn,             // power-on / brown-out reset, async
    input wire logic soft_rstn,        // other resets, async, control registers kept
    input wire logic gate_pin,         // external gate pin
    input wire logic tmr0_ovf,         // overflow of another timer
    input wire logic tmr2_match,       // period match of another timer
    input wire logic other_match,      // further period match source
    input wire logic count_tick,       // counting clock pulse
    output logic count_en,             // counter may advance this tick
    input wire logic [3:0] s_axi_awaddr,  // write address
    input wire logic s_axi_awvalid,    // write address valid
    output logic s_axi_awready,        // write address ready
    input wire logic [31:0] s_axi_wdata,  // write data
    input wire logic [3:0] s_axi_wstrb,   // write strobes
    input wire logic s_axi_wvalid,     // write data valid
    output logic s_axi_wready,         // write data ready
    output logic [1:0] s_axi_bresp,    // write response
    output logic s_axi_bvalid,         // write response valid
    input wire logic s_axi_bready,     // write response ready
    input wire logic [3:0] s_axi_araddr,  // read address
    input wire logic s_axi_arvalid,    // read address valid
    output logic s_axi_arready,        // read address ready
    output logic [31:0] s_axi_rdata,   // read data
    output logic [1:0] s_axi_rresp,    // read response
    output logic s_axi_rvalid,         // read valid
    input wire logic s_axi_rready      // read ready
);
    tgc_ctrl_t ctrl_reg, ctrl_next;
    tgc_sp_t sp_reg, sp_next;
    logic [3:0] meta_reg, meta_next;   // first stage, one bit per gate source
    logic [3:0] sync_reg, sync_next;   // second stage, the only stage logic reads
    logic prev_reg, prev_next;         // selected source one cycle back, for edges
    logic ws_reg, ws_next;             // lane 0 strobe, kept with its write data
    logic tog_reg, tog_next;
    logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
    logic [3:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic src, src_prev, pol_gate, rise, eff_gate, wr_fire;

    function automatic logic [7:0] ctrl_byte(input tgc_ctrl_t c, input logic val);
        ctrl_byte = {c.ge, c.pol, c.tm, c.spm, c.go, val, c.gss};
    endfunction : ctrl_byte

    function automatic logic gate_level(input logic pol, input logic lvl);
        gate_level = pol ? lvl : ~lvl;
    endfunction : gate_level

    // every source is synchronised before the select mux, so the mux never
    // passes a half-settled pin into the edge detector
    always_comb begin
        meta_next = {other_match, tmr2_match, tmr0_ovf, gate_pin};
        sync_next = meta_reg;
        prev_next = src;
    end
    // source select: pin, overflow, match, match [R9]
    assign src = sync_reg[ctrl_reg.gss];
    assign src_prev = prev_reg;
    assign pol_gate = gate_level(ctrl_reg.pol, src);             // [R3]
    assign rise = pol_gate & ~gate_level(ctrl_reg.pol, src_prev);

    always_comb begin
        tog_next = tog_reg;
        if (!ctrl_reg.tm) begin
            tog_next = 1'b0;                                 // [R4]
        end else if (rise && (!ctrl_reg.spm || sp_reg != TGC_SP_IDLE)) begin
            tog_next = ~tog_reg;                             // [R5]
        end
    end
    wire logic cond_gate = ctrl_reg.tm ? tog_reg : pol_gate;

    // single pulse: armed waits for active edge, open until gate ends [R6]
    always_comb begin
        sp_next = sp_reg;
        if (!ctrl_reg.spm) begin
            sp_next = TGC_SP_IDLE;
        end else begin
            case (sp_reg)
                TGC_SP_IDLE: if (ctrl_reg.go) sp_next = TGC_SP_ARMED;
                TGC_SP_ARMED: if (rise) sp_next = TGC_SP_OPEN;
                TGC_SP_OPEN: if (!cond_gate && !ctrl_reg.tm) sp_next = TGC_SP_IDLE;
                default: sp_next = TGC_SP_IDLE;
            endcase
            if (sp_reg == TGC_SP_OPEN && ctrl_reg.tm && rise) sp_next = TGC_SP_IDLE;
        end
    end
    assign eff_gate = ctrl_reg.spm ? (sp_reg == TGC_SP_OPEN) & cond_gate : cond_gate;
    // [R1] [R2]
    assign count_en = ctrl_reg.ton & count_tick & (~ctrl_reg.ge | eff_gate);

    assign s_axi_awready = ~aw_reg & ~bv_reg;
    assign s_axi_wready = ~w_reg & ~bv_reg;
    assign s_axi_arready = ~rv_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = br_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rr_reg;
    assign wr_fire = aw_reg & w_reg;

    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        bv_next = bv_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rd_next = rd_reg;
        rr_next = rr_reg;
        ctrl_next = ctrl_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = TGC_RESP_OKAY;
            if (awa_reg == TGC_ADDR_CTRL) begin
                if (ws_reg) begin
                    ctrl_next.ge = wd_reg[TGC_BIT_GE];
                    ctrl_next.pol = wd_reg[TGC_BIT_POL];
                    ctrl_next.tm = wd_reg[TGC_BIT_TM];
                    ctrl_next.spm = wd_reg[TGC_BIT_SPM];
                    ctrl_next.go = wd_reg[TGC_BIT_GO];
                    ctrl_next.gss = wd_reg[1:0];
                end
            end else if (awa_reg == TGC_ADDR_TMR) begin
                if (ws_reg) ctrl_next.ton = wd_reg[TGC_BIT_TON];
            end else begin
                br_next = TGC_RESP_SLVERR;
            end
        end
        // status clears when the armed gate sees its active edge or mode drops [R7]
        if ((sp_reg == TGC_SP_ARMED && rise && ctrl_reg.spm) || !ctrl_reg.spm) begin
            if (!(wr_fire && awa_reg == TGC_ADDR_CTRL && ctrl_next.spm)) ctrl_next.go = 1'b0;
        end
        if (!ctrl_next.ton) ctrl_next.go = 1'b0;
        if (bv_reg && s_axi_bready) bv_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rr_next = TGC_RESP_OKAY;
            if (s_axi_araddr == TGC_ADDR_CTRL) begin
                rd_next = {24'h0, ctrl_byte(ctrl_reg, cond_gate)};   // [R8]
            end else if (s_axi_araddr == TGC_ADDR_TMR) begin
                rd_next = {31'h0, ctrl_reg.ton};
            end else begin
                rd_next = 32'h0;
                rr_next = TGC_RESP_SLVERR;
            end
        end else if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
    end

    // control bits survive soft reset, cleared only by rstn [R10]
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= tgc_ctrl_t'(TGC_CTRL_RST);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // datapath and bus state cleared by any reset
    always_ff @(posedge clk or negedge rstn or negedge soft_rstn) begin
        if (!rstn || !soft_rstn) begin
            sp_reg <= TGC_SP_IDLE;
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            prev_reg <= 1'b0;
            tog_reg <= 1'b0;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            bv_reg <= 1'b0;
            rv_reg <= 1'b0;
            awa_reg <= 4'h0;
            wd_reg <= 32'h0;
            ws_reg <= 1'b0;
            rd_reg <= 32'h0;
            br_reg <= 2'h0;
            rr_reg <= 2'h0;
        end else begin
            sp_reg <= sp_next;
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
            tog_reg <= tog_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            bv_reg <= bv_next;
            rv_reg <= rv_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            rd_reg <= rd_next;
            br_reg <= br_next;
            rr_reg <= rr_next;
        end
    end

    property p_off_no_count;
        @(posedge clk) disable iff (!rstn) !ctrl_reg.ton |-> !count_en;
    endproperty
    a_off_no_count: assert property (p_off_no_count) else $error("count while timer off"); // [R1]
    property p_gated;
        @(posedge clk) disable iff (!rstn) ctrl_reg.ton && ctrl_reg.ge && !eff_gate |-> !count_en;
    endproperty
    a_gated: assert property (p_gated) else $error("count with gate inactive"); // [R1]
    property p_free;
        @(posedge clk) disable iff (!rstn) ctrl_reg.ton && !ctrl_reg.ge && count_tick |-> count_en;
    endproperty
    a_free: assert property (p_free) else $error("missed free count"); // [R2]
    property p_pol;
        @(posedge clk) disable iff (!rstn) !ctrl_reg.tm && !ctrl_reg.spm
            |-> cond_gate == (ctrl_reg.pol == src);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity wrong"); // [R3]
    property p_tog_clr;
        @(posedge clk) disable iff (!rstn || !soft_rstn) !ctrl_reg.tm |=> !tog_reg;
    endproperty
    a_tog_clr: assert property (p_tog_clr) else $error("toggle not cleared"); // [R4]
    property p_tog;
        @(posedge clk) disable iff (!rstn || !soft_rstn)
            ctrl_reg.tm && $past(ctrl_reg.tm) && !ctrl_reg.spm && rise
            |=> tog_reg != $past(tog_reg);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle missed"); // [R5]
    property p_sp_off;
        @(posedge clk) disable iff (!rstn || !soft_rstn) !ctrl_reg.spm |=> sp_reg == TGC_SP_IDLE;
    endproperty
    a_sp_off: assert property (p_sp_off) else $error("single pulse active while off"); // [R6]
    property p_go_done;
        @(posedge clk) disable iff (!rstn || !soft_rstn)
            ctrl_reg.spm && sp_reg == TGC_SP_ARMED && rise && !wr_fire |=> !ctrl_reg.go;
    endproperty
    a_go_done: assert property (p_go_done) else $error("status not cleared"); // [R7]
    property p_gss;
        @(posedge clk) disable iff (!rstn || !soft_rstn)
            $past(rstn, 2) && $past(soft_rstn, 2) && $past(rstn) && $past(soft_rstn)
            && ctrl_reg.gss == 2'h0 |-> src == $past(gate_pin, 2);
    endproperty
    a_gss: assert property (p_gss) else $error("source select wrong"); // [R9]
    c_gated: cover property (@(posedge clk) disable iff (!rstn) ctrl_reg.ge && count_en);
    c_tog: cover property (@(posedge clk) disable iff (!rstn) ctrl_reg.tm && rise);
    c_sp: cover property (@(posedge clk) disable iff (!rstn) sp_reg == TGC_SP_OPEN);
endmodule : tgc_gate

// *** verif/timer_gate_control_test.sv ***
`timescale 1ns/1ps
module timer_gate_control_test;
    import tgc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic srst_n = 1'b1;
    logic [3:0] src = 4'h0;
    logic tick = 1'b0;
    logic [3:0] strb = 4'h1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic bre = 1'b0;
    logic arv = 1'b0;
    logic rre = 1'b0;
    logic en, awr, wrdy, bv, arr, rv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [1:0] r;
    logic [31:0] seed = 32'hdf702096;
    int n_errors = 0;
    int checks_done = 0;
    always #12.5 clk = ~clk;
    tgc_gate uut (.clk(clk), .rstn(rstn), .soft_rstn(srst_n), .gate_pin(src[0]),
        .tmr0_ovf(src[1]), .tmr2_match(src[2]), .other_match(src[3]), .count_tick(tick),
        .count_en(en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rre));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic exp_en(input logic ton, ge, pol, pin);
        return ton & (!ge | (pin == pol));
    endfunction : exp_en
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error: %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // handshakes are judged at the falling edge so that the combinational
    // readies never race the rising edge that retires a transfer
    task automatic wr(input logic [3:0] a, input logic [7:0] v,
                      input logic [1:0] er = TGC_RESP_OKAY);
        logic ta, tw, tb;
        logic [1:0] rs;
        tb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = awv & awr;
            tw = wv & wrdy;
            tb = bv;
            rs = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        bre <= 1'b0;
        check("bresp", 32'(rs), 32'(er));
    endtask : wr
    task automatic rd(input logic [3:0] a);
        logic ta, tr;
        tr = 1'b0;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            ta = arv & arr;
            tr = rv;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end
        rre <= 1'b0;
    endtask : rd
    // four edges cover the two-flop synchroniser, one for the gate logic and one spare
    task automatic set_src(input logic [3:0] v);
        @(posedge clk);
        src <= v;
        repeat (4) @(posedge clk);
    endtask : set_src
    task automatic tick_chk(input logic e);
        @(posedge clk);
        tick <= 1'b1;
        @(negedge clk);
        check("count_en", 32'(en), 32'(e));
        @(posedge clk);
        tick <= 1'b0;
    endtask : tick_chk
    task automatic gval(input logic e);
        rd(TGC_ADDR_CTRL);
        check("gate_value", 32'(d[TGC_BIT_VAL]), 32'(e));
    endtask : gval
    task automatic reg_chk(input logic [7:0] c, input logic t);
        rd(TGC_ADDR_CTRL);
        check("ctrl", d & 32'hfb, {24'h0, c});
        rd(TGC_ADDR_TMR);
        check("timer_on", d, 32'(t));
    endtask : reg_chk
    initial begin
        #(25 * 40000);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        reg_chk(8'h00, 1'b0);
        rd(4'h8);
        check("unmapped_resp", 32'(r), 32'(TGC_RESP_SLVERR));
        check("unmapped_data", d, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            wr(TGC_ADDR_CTRL, {seed[0], seed[1], 6'h0});
            wr(TGC_ADDR_TMR, {7'h0, seed[2]});
            set_src({3'h0, seed[3]});
            tick_chk(exp_en(seed[2], seed[0], seed[1], seed[3]));
            gval(seed[3] == seed[1]);
        end
        $display("test random gating done");
        wr(TGC_ADDR_TMR, 8'h01);
        for (int s = 0; s < 4; s++) begin
            wr(TGC_ADDR_CTRL, 8'h40 | 8'(s));
            set_src(~(4'h1 << s));
            gval(1'b0);
            set_src(4'h1 << s);
            gval(1'b1);
        end
        $display("test source select done");
        wr(TGC_ADDR_CTRL, 8'he0);
        set_src(4'h1);
        set_src(4'h0);
        tick_chk(1'b1);
        gval(1'b1);
        set_src(4'h1);
        set_src(4'h0);
        tick_chk(1'b0);
        set_src(4'h1);
        set_src(4'h0);
        wr(TGC_ADDR_CTRL, 8'hc0);
        wr(TGC_ADDR_CTRL, 8'he0);
        tick_chk(1'b0);
        $display("test toggle done");
        wr(TGC_ADDR_CTRL, 8'hd0);
        wr(TGC_ADDR_CTRL, 8'hd8);
        rd(TGC_ADDR_CTRL);
        check("go_armed", 32'(d[TGC_BIT_GO]), 32'h1);
        tick_chk(1'b0);
        set_src(4'h1);
        tick_chk(1'b1);
        rd(TGC_ADDR_CTRL);
        check("go_done", 32'(d[TGC_BIT_GO]), 32'h0);
        set_src(4'h0);
        set_src(4'h1);
        tick_chk(1'b0);
        wr(TGC_ADDR_CTRL, 8'hc0);
        tick_chk(1'b1);
        wr(TGC_ADDR_CTRL, 8'hf0);
        set_src(4'h0);
        wr(TGC_ADDR_CTRL, 8'hf8);
        set_src(4'h1);
        tick_chk(1'b1);
        set_src(4'h0);
        set_src(4'h1);
        tick_chk(1'b0);
        $display("test single pulse done");
        strb <= 4'h0;
        wr(TGC_ADDR_CTRL, 8'h0f);
        strb <= 4'h1;
        wr(4'hc, 8'hff, TGC_RESP_SLVERR);
        reg_chk(8'hf0, 1'b1);
        $display("test write lanes done");
        wr(TGC_ADDR_CTRL, 8'hc1);
        @(posedge clk);
        srst_n <= 1'b0;
        @(posedge clk);
        srst_n <= 1'b1;
        reg_chk(8'hc1, 1'b1);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        reg_chk(8'h00, 1'b0);
        $display("test reset kinds done");
        summarize();
    end
endmodule : timer_gate_control_test
